// File: rtl/break_condition_compare.sv
// Break condition compare for two break channels, with register port and match interrupt.
// Assumes CPU bus cycle signals and the current space identifier are synchronous to clk_in.
//
// Summary of operation
// (R01) Each channel compares its 8-bit space identifier with the current MMU identifier.
// (R02) Address, identifier and mask registers are not reset; undefined until written.
// (R03) Mask bit 2 clear compares all identifier bits; set drops the identifier.
// (R04) Mask bits 1:0 select full, low-10 ignored, low-12 ignored, or no address.
// (R05) Mask register bits 7:3 read zero; software writes zero there.
// (R06) Channel B registers have the same layout and meaning as channel A.
// (R07) Bus-cycle condition registers reset to all zeros.
// (R08) Condition register bits 15:6 read zero; software writes zero there.
// (R09) Type field 5:4: none, fetch only, data only, or either.
// (R10) Direction field 3:2: none, read, write, or both.
// (R11) Size field 1:0: any size, byte, word, or longword.
// (R12) Break address holds a logical address compared with the cycle's address.
// (R13) A match sets the channel flag; only a software write of zero clears it. Reset also clears it here.
// (R14) A match needs every enabled condition true in the same bus cycle.
`timescale 1ns/1ps
`default_nettype none

module break_condition_compare
  import break_cmp_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        nrst_in,
  // Register port
  input  wire logic [break_cmp_pkg::REG_AW-1:0] reg_addr_in,
  input  wire logic [break_cmp_pkg::DATA_W-1:0] reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic [break_cmp_pkg::DATA_W-1:0] reg_rdata_out,
  // CPU bus cycle and MMU identifier
  input  wire logic                        bus_valid_in,
  input  wire logic [break_cmp_pkg::ADDR_W-1:0] bus_addr_in,
  input  wire logic                        bus_fetch_in,
  input  wire logic                        bus_write_in,
  input  wire logic [1:0]                  bus_size_in,
  input  wire logic [break_cmp_pkg::ID_W-1:0]   page_entry_high_reg_in,
  // Match reporting
  output logic                             chan_a_match_out,
  output logic                             chan_b_match_out,
  output logic                             chan_a_match_flag_out,
  output logic                             chan_b_match_flag_out,
  output logic                             irq_out
);

  import break_cmp_pkg::*;

  // Refuse at elaboration any widths that the decode cannot serve
  if (ADDR_W <= LOW_BITS_12 || ID_W < 1 || REG_AW < 6 || NUM_CHAN != 2) begin : g_bad_widths
    $error("unsupported width settings");
  end

  typedef struct packed {
    logic [NUM_CHAN-1:0][ADDR_W-1:0] addr;
    logic [NUM_CHAN-1:0][ID_W-1:0]   id;
    logic [NUM_CHAN-1:0][MASK_W-1:0] mask;
    logic [NUM_CHAN-1:0][COND_W-1:0] cond;
    logic [NUM_CHAN-1:0]             flags;
    logic [NUM_CHAN-1:0]             irq_stat;
    logic [NUM_CHAN-1:0]             irq_en;
    logic [NUM_CHAN-1:0]             match;
    logic                            irq;
    logic [DATA_W-1:0]               rdata;
  } state_t;

  state_t              state;
  state_t              next_state;
  logic [NUM_CHAN-1:0] hit;
  logic [NUM_CHAN-1:0] hit_ev;

  // True when the register address selects a per-channel register
  function automatic logic chan_sel(input logic [REG_AW-1:0] a, input int ch,
                                    input logic [7:0] ofs);
    logic [7:0] full;
    full     = 8'(ch * CHAN_STRIDE) + ofs;
    chan_sel = (a == REG_AW'(full));
  endfunction

  // True when the register address selects a common register
  function automatic logic com_sel(input logic [REG_AW-1:0] a, input logic [7:0] ofs);
    com_sel = (a == REG_AW'(ofs));
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_chan
      channel_compare u_cmp (
        .cfg_addr_in     (state.addr[g]),
        .cfg_id_in       (state.id[g]),
        .cfg_mask_in     (state.mask[g]),
        .cfg_cond_in     (state.cond[g]),
        .bus_addr_in     (bus_addr_in),
        .bus_fetch_in    (bus_fetch_in),
        .bus_write_in    (bus_write_in),
        .bus_size_in     (bus_size_in),
        .cur_space_id_in (page_entry_high_reg_in),
        .hit_out         (hit[g])
      ); // R06
    end
  endgenerate

  always_comb begin
    logic [DATA_W-1:0] word;
    word       = '0;
    next_state = state;
    next_state.match = '0;
    next_state.rdata = '0;
    // Once a flag is up, its channel reports nothing new until software or reset clears it
    hit_ev = {NUM_CHAN{bus_valid_in}} & hit & ~state.flags; // R13 R14
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      if (reg_wr_in && chan_sel(reg_addr_in, ch, OFS_ADDR)) begin
        next_state.addr[ch] = reg_wdata_in[ADDR_W-1:0]; // R12
      end
      if (reg_wr_in && chan_sel(reg_addr_in, ch, OFS_ID)) begin
        next_state.id[ch] = reg_wdata_in[ID_W-1:0]; // R01
      end
      if (reg_wr_in && chan_sel(reg_addr_in, ch, OFS_MASK)) begin
        next_state.mask[ch] = reg_wdata_in[MASK_W-1:0]; // R05
      end
      if (reg_wr_in && chan_sel(reg_addr_in, ch, OFS_COND)) begin
        next_state.cond[ch] = reg_wdata_in[COND_W-1:0]; // R08
      end
      if (chan_sel(reg_addr_in, ch, OFS_ADDR)) begin
        word = DATA_W'(state.addr[ch]);
      end
      if (chan_sel(reg_addr_in, ch, OFS_ID)) begin
        word = DATA_W'(state.id[ch]);
      end
      if (chan_sel(reg_addr_in, ch, OFS_MASK)) begin
        word = DATA_W'(state.mask[ch]); // R05
      end
      if (chan_sel(reg_addr_in, ch, OFS_COND)) begin
        word = DATA_W'(state.cond[ch]); // R08
      end
    end
    // Flags: writing 0 clears, writing 1 keeps; a match in the clearing cycle is masked by the set flag, so the clear wins
    if (reg_wr_in && com_sel(reg_addr_in, OFS_FLAGS)) begin
      next_state.flags = state.flags & reg_wdata_in[NUM_CHAN-1:0]; // R13
    end
    next_state.flags = next_state.flags | hit_ev; // R13
    next_state.match = hit_ev; // R14
    if (reg_wr_in && com_sel(reg_addr_in, OFS_IRQ_CLR)) begin
      next_state.irq_stat = state.irq_stat & ~reg_wdata_in[NUM_CHAN-1:0];
    end
    next_state.irq_stat = next_state.irq_stat | hit_ev;
    if (reg_wr_in && com_sel(reg_addr_in, OFS_IRQ_EN)) begin
      next_state.irq_en = reg_wdata_in[NUM_CHAN-1:0];
    end
    next_state.irq = |(next_state.irq_stat & next_state.irq_en);
    if (com_sel(reg_addr_in, OFS_FLAGS)) begin
      word = DATA_W'(state.flags);
    end
    if (com_sel(reg_addr_in, OFS_IRQ_STAT)) begin
      word = DATA_W'(state.irq_stat);
    end
    if (com_sel(reg_addr_in, OFS_IRQ_EN)) begin
      word = DATA_W'(state.irq_en);
    end
    if (reg_rd_in) begin
      next_state.rdata = word;
    end
  end

  // Address, identifier and mask keep their value through reset; condition and control state are cleared
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state.cond     <= {NUM_CHAN{COND_RESET}}; // R07 R02
      state.flags    <= FLAGS_RESET;
      state.irq_stat <= IRQ_RESET;
      state.irq_en   <= IRQ_RESET;
      state.match    <= '0;
      state.irq      <= 1'b0;
      state.rdata    <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata_out         = state.rdata;
  assign chan_a_match_out      = state.match[0];
  assign chan_b_match_out      = state.match[1];
  assign chan_a_match_flag_out = state.flags[0];
  assign chan_b_match_flag_out = state.flags[1];
  assign irq_out               = state.irq;

  // Checks
  sequence fresh_hit_a_s;
    bus_valid_in && hit[0] && !state.flags[0];
  endsequence

  sequence flag_report_a_s;
    chan_a_match_out && chan_a_match_flag_out;
  endsequence

  match_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R13
    fresh_hit_a_s |=> flag_report_a_s)
    else $error("channel A match not reported with flag");

  match_cause_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R14
    chan_b_match_out |-> ($past(bus_valid_in) && $past(hit[1]) && !$past(state.flags[1])))
    else $error("channel B match without a qualifying cycle");

  flag_sticky_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R13
    (state.flags[0] && !(reg_wr_in && reg_addr_in == REG_AW'(OFS_FLAGS))) |=> state.flags[0])
    else $error("channel A flag dropped without software clear");

  space_id_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R01
    (hit[0] && !state.mask[0][MASK_ID_BIT]) |-> (page_entry_high_reg_in == state.id[0]))
    else $error("identifier compare ignored while enabled");

  addr_full_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R04
    (hit[1] && state.mask[1][1:0] == ADDR_SEL_ALL) |-> (bus_addr_in == state.addr[1]))
    else $error("full address compare failed on channel B");

  addr_low12_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R06
    (hit[1] && state.mask[1][1:0] == ADDR_SEL_12) |->
      (bus_addr_in[ADDR_W-1:LOW_BITS_12] == state.addr[1][ADDR_W-1:LOW_BITS_12]))
    else $error("12-bit masked address compare failed");

  addr_low10_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R04
    (hit[0] && state.mask[0][1:0] == ADDR_SEL_10) |->
      (bus_addr_in[ADDR_W-1:LOW_BITS_10] == state.addr[0][ADDR_W-1:LOW_BITS_10]))
    else $error("10-bit masked address compare failed");

  type_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R09
    (state.cond[0][COND_TYPE_HI:COND_TYPE_LO] == 2'h0) |-> !hit[0])
    else $error("hit with cycle type disabled");

  dir_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R10
    (state.cond[1][COND_DIR_HI:COND_DIR_LO] == 2'h0) |-> !hit[1])
    else $error("hit with direction disabled");

  size_match_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R11
    (hit[0] && state.cond[0][COND_SIZE_HI:COND_SIZE_LO] != SIZE_ANY) |->
      (bus_size_in == state.cond[0][COND_SIZE_HI:COND_SIZE_LO]))
    else $error("operand size mismatch on hit");

  mask_rsvd_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R05
    (reg_rd_in && reg_addr_in == REG_AW'(OFS_MASK)) |=> (reg_rdata_out[DATA_W-1:MASK_W] == '0))
    else $error("mask register reserved bits not zero");

  cond_rsvd_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R08
    (reg_rd_in && reg_addr_in == REG_AW'(OFS_COND)) |=> (reg_rdata_out[DATA_W-1:COND_W] == '0))
    else $error("condition register reserved bits not zero");

  cond_reset_a: assert property (@(posedge clk_in) // R07
    !nrst_in |-> (state.cond == '0 && !irq_out))
    else $error("condition registers not cleared by reset");

  irq_level_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    irq_out == |(state.irq_stat & state.irq_en))
    else $error("interrupt level disagrees with status and enable");

  sequence fresh_hit_b_s;
    bus_valid_in && hit[1] && !state.flags[1];
  endsequence

  sequence flag_report_b_s;
    chan_b_match_out && chan_b_match_flag_out;
  endsequence

  chb_match_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R06 R13
    fresh_hit_b_s |=> flag_report_b_s)
    else $error("channel B match not reported with flag");

  cha_match_cause_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R14
    chan_a_match_out |-> ($past(bus_valid_in) && $past(hit[0]) && !$past(state.flags[0])))
    else $error("channel A match without a qualifying cycle");

  cha_flag_blocks_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R13
    (bus_valid_in && state.flags[0]) |=> !chan_a_match_out)
    else $error("channel A match reported while its flag was set");

  chb_flag_sticky_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R13
    (state.flags[1] && !(reg_wr_in && reg_addr_in == REG_AW'(OFS_FLAGS))) |=> state.flags[1])
    else $error("channel B flag dropped without software clear");

  chb_space_id_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R01 R06
    (hit[1] && !state.mask[1][MASK_ID_BIT]) |-> (page_entry_high_reg_in == state.id[1]))
    else $error("channel B identifier compare ignored while enabled");

  cha_addr_full_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R04 R12
    (hit[0] && state.mask[0][1:0] == ADDR_SEL_ALL) |-> (bus_addr_in == state.addr[0]))
    else $error("full address compare failed on channel A");

  chb_type_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R09
    (state.cond[1][COND_TYPE_HI:COND_TYPE_LO] == 2'h0) |-> !hit[1])
    else $error("channel B hit with cycle type disabled");

  cha_dir_off_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R10
    (state.cond[0][COND_DIR_HI:COND_DIR_LO] == 2'h0) |-> !hit[0])
    else $error("channel A hit with direction disabled");

  cha_fetch_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R09
    (hit[0] && state.cond[0][COND_TYPE_HI:COND_TYPE_LO] == 2'h1) |-> bus_fetch_in)
    else $error("fetch-only channel hit on a data access");

  chb_read_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R10
    (hit[1] && state.cond[1][COND_DIR_HI:COND_DIR_LO] == 2'h1) |-> !bus_write_in)
    else $error("read-only channel hit on a write");

  chb_size_match_a: assert property (@(posedge clk_in) disable iff (!nrst_in) // R11
    (hit[1] && state.cond[1][COND_SIZE_HI:COND_SIZE_LO] != SIZE_ANY) |->
      (bus_size_in == state.cond[1][COND_SIZE_HI:COND_SIZE_LO]))
    else $error("channel B operand size mismatch on hit");

  irq_stat_set_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (bus_valid_in && hit[0] && !state.flags[0]) |=> state.irq_stat[0])
    else $error("interrupt status not set by a channel A match");

  rdata_idle_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !reg_rd_in |=> (reg_rdata_out == '0))
    else $error("read data not zero outside a read answer");

endmodule

`default_nettype wire

// File: common/break_cmp_pkg.sv
// Constants shared by the break condition compare block and its channel comparator.
// Assumes a word-aligned register port with 32-bit data.
package break_cmp_pkg;

  // Widths
  localparam int ADDR_W   = 32;
  localparam int ID_W     = 8;
  localparam int DATA_W   = 32;
  localparam int REG_AW   = 8;
  localparam int NUM_CHAN = 2;
  localparam int MASK_W   = 3;
  localparam int COND_W   = 6;

  // Register map: per-channel block at base + stride * channel
  localparam logic [7:0] CHAN_STRIDE  = 8'h10;
  localparam logic [7:0] OFS_ADDR     = 8'h00;
  localparam logic [7:0] OFS_ID       = 8'h04;
  localparam logic [7:0] OFS_MASK     = 8'h08;
  localparam logic [7:0] OFS_COND     = 8'h0c;
  localparam logic [7:0] OFS_FLAGS    = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h28;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h2c;

  // Address-mask register fields
  localparam int MASK_ID_BIT = 2;
  localparam int MASK_SEL_HI = 1;
  localparam int MASK_SEL_LO = 0;
  localparam logic [1:0] ADDR_SEL_ALL  = 2'h0;
  localparam logic [1:0] ADDR_SEL_10   = 2'h1;
  localparam logic [1:0] ADDR_SEL_12   = 2'h2;
  localparam logic [1:0] ADDR_SEL_NONE = 2'h3;
  localparam int LOW_BITS_10 = 10;
  localparam int LOW_BITS_12 = 12;

  // Bus-cycle condition register fields
  localparam int COND_TYPE_HI = 5;
  localparam int COND_TYPE_LO = 4;
  localparam int COND_DIR_HI  = 3;
  localparam int COND_DIR_LO  = 2;
  localparam int COND_SIZE_HI = 1;
  localparam int COND_SIZE_LO = 0;
  localparam logic [1:0] SIZE_ANY = 2'h0;

  // Reset values
  localparam logic [COND_W-1:0]   COND_RESET  = 6'h00;
  localparam logic [NUM_CHAN-1:0] FLAGS_RESET = 2'h0;
  localparam logic [NUM_CHAN-1:0] IRQ_RESET   = 2'h0;

endpackage

// File: rtl/channel_compare.sv
// One break channel: combinational compare of a CPU bus cycle against stored conditions.
// Assumes the caller qualifies the hit with a valid bus cycle and registers it.
`timescale 1ns/1ps
`default_nettype none

module channel_compare
  import break_cmp_pkg::*;
(
  // Stored conditions
  input  wire logic [ADDR_W-1:0] cfg_addr_in,
  input  wire logic [ID_W-1:0]   cfg_id_in,
  input  wire logic [MASK_W-1:0] cfg_mask_in,
  input  wire logic [COND_W-1:0] cfg_cond_in,
  // Current bus cycle
  input  wire logic [ADDR_W-1:0] bus_addr_in,
  input  wire logic              bus_fetch_in,
  input  wire logic              bus_write_in,
  input  wire logic [1:0]        bus_size_in,
  input  wire logic [ID_W-1:0]   cur_space_id_in,
  // Result
  output logic                   hit_out
);

  logic       addr_ok;
  logic       id_ok;
  logic       type_ok;
  logic       dir_ok;
  logic       size_ok;
  logic [1:0] addr_sel;
  logic [1:0] size_sel;

  always_comb begin
    addr_sel = cfg_mask_in[MASK_SEL_HI:MASK_SEL_LO];
    size_sel = cfg_cond_in[COND_SIZE_HI:COND_SIZE_LO];
    addr_ok  = 1'b1;
    unique case (addr_sel)
      ADDR_SEL_ALL:  addr_ok = (bus_addr_in == cfg_addr_in); // R04 R12
      ADDR_SEL_10:   addr_ok = (bus_addr_in[ADDR_W-1:LOW_BITS_10] ==
                                cfg_addr_in[ADDR_W-1:LOW_BITS_10]); // R04
      ADDR_SEL_12:   addr_ok = (bus_addr_in[ADDR_W-1:LOW_BITS_12] ==
                                cfg_addr_in[ADDR_W-1:LOW_BITS_12]); // R04
      ADDR_SEL_NONE: addr_ok = 1'b1; // R04
    endcase
    id_ok   = cfg_mask_in[MASK_ID_BIT] | (cur_space_id_in == cfg_id_in); // R01 R03
    // Fetch selects the low type bit, data access the high one; 00 never matches
    type_ok = bus_fetch_in ? cfg_cond_in[COND_TYPE_LO] : cfg_cond_in[COND_TYPE_HI]; // R09
    dir_ok  = bus_write_in ? cfg_cond_in[COND_DIR_HI] : cfg_cond_in[COND_DIR_LO]; // R10
    size_ok = (size_sel == SIZE_ANY) | (bus_size_in == size_sel); // R11
    hit_out = addr_ok & id_ok & type_ok & dir_ok & size_ok; // R14
  end

endmodule

`default_nettype wire

// File: tb/cpu_bus_model.sv
// CPU core and MMU stand-in: presents one bus cycle per one-clock request.
// Assumes the bench raises go_in for one clock per cycle wanted.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  // Clock
  input  wire logic        clk_in,
  // Requests
  input  wire logic        go_in,
  input  wire logic [31:0] addr_in,
  input  wire logic        fetch_in,
  input  wire logic        write_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [7:0]  id_in,
  // Bus cycle
  output logic             valid_out,
  output logic [31:0]      addr_out,
  output logic             fetch_out,
  output logic             write_out,
  output logic [1:0]       size_out,
  output logic [7:0]       id_out
);
  logic [31:0] churn = 32'h0;
  always_ff @(posedge clk_in) begin
    valid_out <= go_in;
    id_out    <= id_in;
    churn     <= churn + 32'h9e3779b9;
    if (go_in) begin
      addr_out  <= addr_in;
      fetch_out <= fetch_in;
      write_out <= write_in;
      size_out  <= size_in;
    end else begin
      // Idle cycles show a changing pattern, never the last cycle
      addr_out  <= churn;
      fetch_out <= churn[3];
      write_out <= churn[7];
      size_out  <= churn[9:8];
    end
  end
endmodule
`default_nettype wire

// File: tb/break_condition_compare_tb.sv
// Self-checking bench for the break condition compare block.
// Assumes the package register map and one-cycle answers on every port.
`timescale 1ns/1ps
`default_nettype none
module break_condition_compare_tb;
  import break_cmp_pkg::*;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b1;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic        go = 1'b0;
  logic [31:0] p_addr = 32'h0;
  logic        p_fetch = 1'b0;
  logic        p_write = 1'b0;
  logic [1:0]  p_size = 2'h1;
  logic [7:0]  p_id = 8'h00;
  logic        bus_valid_in, bus_fetch_in, bus_write_in;
  logic [31:0] bus_addr_in;
  logic [1:0]  bus_size_in;
  logic [7:0]  page_entry_high_reg_in;
  logic        chan_a_match_out, chan_b_match_out, irq_out;
  logic        chan_a_match_flag_out, chan_b_match_flag_out;
  int          failures = 0;
  int          n_checks = 0;
  int          seed = int'(32'h2c9ed7d6);
  logic [31:0] rd_q[$];
  logic [1:0]  m_q[$];
  logic [1:0]  f_q[$];
  logic [1:0]  flags_seen;
  logic        rd_last = 1'b0;
  logic        bv_last = 1'b0;
  logic [1:0]  fl = 2'h0;
  logic [31:0] cf_addr[2];
  logic [7:0]  cf_id[2];
  logic [2:0]  cf_mask[2];
  logic [5:0]  cf_cond[2];
  logic [31:0] r;
  logic [31:0] pat[4] = '{32'h0, 32'h3ff, 32'hfff, 32'h1000};

  initial begin
    forever #4 clk_in = ~clk_in;
  end

  assign flags_seen = {chan_b_match_flag_out, chan_a_match_flag_out};

  break_condition_compare i_break_condition_compare (
    .clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .bus_valid_in(bus_valid_in), .bus_addr_in(bus_addr_in),
    .bus_fetch_in(bus_fetch_in), .bus_write_in(bus_write_in), .bus_size_in(bus_size_in),
    .page_entry_high_reg_in(page_entry_high_reg_in), .chan_a_match_out(chan_a_match_out),
    .chan_b_match_out(chan_b_match_out), .chan_a_match_flag_out(chan_a_match_flag_out),
    .chan_b_match_flag_out(chan_b_match_flag_out), .irq_out(irq_out));

  cpu_bus_model i_cpu_bus_model (
    .clk_in(clk_in), .go_in(go), .addr_in(p_addr), .fetch_in(p_fetch), .write_in(p_write),
    .size_in(p_size), .id_in(p_id), .valid_out(bus_valid_in), .addr_out(bus_addr_in),
    .fetch_out(bus_fetch_in), .write_out(bus_write_in), .size_out(bus_size_in),
    .id_out(page_entry_high_reg_in));

  function automatic logic hit(input int c, input logic [31:0] a, input logic f,
                               input logic w, input logic [1:0] s, input logic [7:0] i);
    logic am, im, tm, dm, sm;
    case (cf_mask[c][1:0])
      2'h0: am = (cf_addr[c] == a);
      2'h1: am = (cf_addr[c][31:10] == a[31:10]);
      2'h2: am = (cf_addr[c][31:12] == a[31:12]);
      default: am = 1'b1;
    endcase
    im = cf_mask[c][2] | (cf_id[c] == i);
    tm = (cf_cond[c][5:4] == 2'h3) | (cf_cond[c][5:4] == {~f, f});
    dm = (cf_cond[c][3:2] == 2'h3) | (cf_cond[c][3:2] == {w, ~w});
    sm = (cf_cond[c][1:0] == 2'h0) | (cf_cond[c][1:0] == s);
    return am & im & tm & dm & sm;
  endfunction

  task automatic check_rd(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic check_match(input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic check_flag(input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic check_irq(input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic final_report;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    rd_q.push_back(e);
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
  endtask

  task automatic cfg(input int c, input logic [31:0] a, input logic [7:0] i,
                     input logic [2:0] m, input logic [5:0] k);
    logic [7:0] b;
    b = c ? CHAN_STRIDE : 8'h00;
    cf_addr[c] = a;
    cf_id[c]   = i;
    cf_mask[c] = m;
    cf_cond[c] = k;
    wr(b + OFS_ADDR, a);
    wr(b + OFS_ID, {24'h0, i});
    wr(b + OFS_MASK, {29'h0, m});
    wr(b + OFS_COND, {26'h0, k});
  endtask

  task automatic cyc(input logic [31:0] a, input logic f, input logic w,
                     input logic [1:0] s, input logic [7:0] i);
    logic [1:0] e;
    @(posedge clk_in);
    go      <= 1'b1;
    p_addr  <= a;
    p_fetch <= f;
    p_write <= w;
    p_size  <= s;
    p_id    <= i;
    e = {hit(1, a, f, w, s, i), hit(0, a, f, w, s, i)} & ~fl;
    fl = fl | e;
    m_q.push_back(e);
    f_q.push_back(fl);
    @(posedge clk_in);
    go      <= 1'b0;
  endtask

  // Results appear one cycle after the request that caused them
  always @(negedge clk_in) begin
    if (rd_last) check_rd(rd_q.pop_front(), reg_rdata_out);
    if (bv_last) check_match(m_q.pop_front(), {chan_b_match_out, chan_a_match_out});
    if (bv_last) check_flag(f_q.pop_front(), flags_seen);
    rd_last = reg_rd_in;
    bv_last = bus_valid_in;
  end

  initial begin
    #400000;
    failures++;
    final_report;
  end

  initial begin
    nrst_in <= 1'b0;
    repeat (16) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(OFS_COND, 32'h0);
    rd(CHAN_STRIDE + OFS_COND, 32'h0);
    wr(OFS_MASK, 32'hffff_ff07);
    rd(OFS_MASK, 32'h7);
    wr(CHAN_STRIDE + OFS_COND, 32'hffff_003f);
    rd(CHAN_STRIDE + OFS_COND, 32'h3f);
    cfg(0, 32'h8765_4321, 8'ha5, 3'h7, 6'h3c);
    cfg(1, 32'h1357_9bdf, 8'h3c, 3'h7, 6'h3c);
    wr(OFS_IRQ_EN, 32'h1);
    cyc(32'h0, 1'b0, 1'b1, 2'h2, 8'h11);
    cyc(32'h0, 1'b1, 1'b0, 2'h1, 8'h22);
    rd(OFS_FLAGS, 32'h3);
    rd(OFS_IRQ_STAT, 32'h3);
    @(negedge clk_in);
    check_irq(1'b1, irq_out);
    wr(OFS_FLAGS, 32'h1);
    fl = 2'h1;
    rd(OFS_FLAGS, 32'h1);
    wr(OFS_IRQ_CLR, 32'h1);
    rd(OFS_IRQ_STAT, 32'h2);
    rd(OFS_IRQ_CLR, 32'h0);
    rd(8'h30, 32'h0);
    @(negedge clk_in);
    check_irq(1'b0, irq_out);
    check_flag(2'h1, flags_seen);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    fl = 2'h0;
    rd(OFS_ADDR, 32'h8765_4321);
    rd(CHAN_STRIDE + OFS_ID, 32'h3c);
    rd(OFS_COND, 32'h0);
    for (int n = 0; n < 150; n++) begin
      for (int c = 0; c < 2; c++) begin
        cfg(c, $random(seed), 8'($random(seed)), 3'($random(seed)), 6'($random(seed)));
      end
      wr(OFS_FLAGS, 32'h0);
      fl = 2'h0;
      for (int k = 0; k < 2; k++) begin
        r = $random(seed);
        cyc(cf_addr[n % 2] ^ (32'($random(seed)) & pat[r[1:0]]), r[6], r[7],
            (r[5:4] == 2'h0) ? 2'h3 : r[5:4], r[2] ? cf_id[n % 2] : r[15:8]);
      end
    end
    repeat (4) @(posedge clk_in);
    final_report;
  end
endmodule
`default_nettype wire
